// ---- hdl/tcci_filter.sv ----
// Spike filter for one synchronised serial line
`timescale 1ns/1ps
`default_nettype none
module tcci_filter #(
   parameter int LEN = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic din,
   output logic dout
);
   // Two agreeing samples suffice: a 50 ns spike fits in one 100 ns sample
   logic [LEN-1:0] hist;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hist <= '1;
         dout <= 1'b1;
      end else begin
         hist <= LEN'({hist, din});
         // Level accepted only once stable for longer than a spike
         if (&{hist, din})
            dout <= 1'b1;
         else if (~|{hist, din})
            dout <= 1'b0;
      end
   end
endmodule : tcci_filter
`default_nettype wire

// ---- hdl/tcci_pkg.sv ----
// Shared constants for the Type-C port control block
package tcci_pkg;
   localparam logic [7:0] TCCI_REG_ID = 8'h01;
   localparam logic [7:0] TCCI_REG_CONTROL = 8'h02;
   localparam logic [7:0] TCCI_REG_EVENT_FLAGS = 8'h03;
   localparam logic [7:0] TCCI_REG_ATTACH_STATUS = 8'h04;
   localparam logic [7:0] TCCI_LAST_REG = 8'h04;
   localparam logic [6:0] TCCI_ADDR_BASE = 7'h0d;
   localparam int TCCI_ADDR_SEL_BIT = 5;
   localparam int TCCI_CTL_MASK_BIT = 0;
   localparam int TCCI_CTL_ROLE_LO = 1;
   localparam int TCCI_CTL_CUR_LO = 3;
   localparam int TCCI_CTL_SLEEP_BIT = 7;
   localparam int TCCI_EV_ATTACH_BIT = 0;
   localparam int TCCI_EV_DETACH_BIT = 1;
   localparam int TCCI_EV_FAULT_BIT = 2;
   localparam logic [7:0] TCCI_CONTROL_RST = 8'h00;
   localparam logic [7:0] TCCI_EVENT_RST = 8'h00;
   localparam logic [1:0] TCCI_ROLE_DEVICE = 2'h0;
   localparam logic [1:0] TCCI_ROLE_HOST = 2'h1;
   localparam logic [1:0] TCCI_ROLE_DUAL = 2'h2;
   localparam logic [7:0] TCCI_ID_VALUE = 8'h00;
   localparam int TCCI_CLK_NS = 100;
   localparam int TCCI_SPIKE_NS = 50;
   localparam int TCCI_SPIKE_CYC = (TCCI_SPIKE_NS + TCCI_CLK_NS - 1)
                                   / TCCI_CLK_NS;
   localparam int TCCI_TOGGLE_MS = 50;
   localparam int TCCI_TOGGLE_CYC = TCCI_TOGGLE_MS * 1000000 / TCCI_CLK_NS;
endpackage : tcci_pkg

// ---- hdl/tcci_top.sv ----
// I2C target, control, interrupt and role logic of the Type-C port block
// Summary of operation
// - Spikes up to 50 ns on serial clock and data are rejected.
// - Mode select tied high or low enables I2C; sets address bit 5.
// - Floating mode select puts the part in pin control mode.
// - No offset byte; transfers start at first register, go in order.
// - Interrupt output goes low when event or status registers change.
// - Reading event register clears its flags and releases interrupt.
// - Control bit 0 masks interrupts; output stays released while set.
// - Power-on reset puts all registers and I2C logic to defaults.
// - Control bits 2:1 load role from role pin; writes may change.
// - Host role sources current at set level; device role pulls down.
// - Dual role toggles every 50 ms until a connection is made.
// - Host role selects advertised current; device role reports it.
// - Attach pin low only for host-role device attach.
// - Audio and debug accessory attach reported in attach status.
// - Device role attach decided from bus power sense.
// - Enable high disables outputs except CC and I2C.
// - Every enable edge resets I2C port and connection; control kept.
// - Enable low restarts connection logic and attach detection.
// - VCONN over-current pulls interrupt output low.
`timescale 1ns/1ps
`default_nettype none
module tcci_top
   import tcci_pkg::*;
#(
   parameter int TOGGLE_CYC = TCCI_TOGGLE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe,
   output logic sda_out,
   input wire logic mode_sel_high,
   input wire logic mode_sel_float,
   input wire logic [1:0] role_pin,
   input wire logic enable_in_n,
   input wire logic bus_power_sense,
   input wire logic overcurrent_event,
   input wire logic cc_attach,
   input wire logic [1:0] cc_host_current,
   input wire logic cc_audio,
   input wire logic cc_debug,
   output logic irq_out_n,
   output logic irq_oe,
   output logic attach_indicator_pin,
   output logic attach_oe,
   output logic cc_source_on,
   output logic [1:0] cc_source_level,
   output logic cc_pulldown_on,
   output logic i2c_mode
);
   typedef enum logic [3:0] {
      TCCI_IDLE = 4'b0001,
      TCCI_ADDR = 4'b0010,
      TCCI_WR = 4'b0100,
      TCCI_RD = 4'b1000
   } tcci_state_t;

   logic [1:0] scl_sy, sda_sy, en_sy, vb_sy, oc_sy, ms_sy, mf_sy;
   logic scl_f, sda_f, scl_d, sda_d;
   logic en, en_d, vb, oc, oc_d;
   tcci_state_t state;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic [7:0] ptr, rd_ptr;
   logic ack_phase, rd_nack;
   logic [7:0] control, event_flags, attach_status, rd_byte;
   logic host_now, attached, attached_d;
   logic [31:0] tog_cnt;
   logic role_loaded, flags_clr, ctl_wr;
   logic [7:0] next_status;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         en_sy <= 2'h3;
         vb_sy <= 2'h0;
         oc_sy <= 2'h0;
         ms_sy <= 2'h0;
         mf_sy <= 2'h0;
      end else begin
         scl_sy <= {scl_sy[0], scl_in};
         sda_sy <= {sda_sy[0], sda_in};
         en_sy <= {en_sy[0], enable_in_n};
         vb_sy <= {vb_sy[0], bus_power_sense};
         oc_sy <= {oc_sy[0], overcurrent_event};
         ms_sy <= {ms_sy[0], mode_sel_high};
         mf_sy <= {mf_sy[0], mode_sel_float};
      end
   end

   tcci_filter #(.LEN(TCCI_SPIKE_CYC)) u_scl (
      .clk(clk), .rstn(rstn), .din(scl_sy[1]), .dout(scl_f));
   tcci_filter #(.LEN(TCCI_SPIKE_CYC)) u_sda (
      .clk(clk), .rstn(rstn), .din(sda_sy[1]), .dout(sda_f));

   assign en = ~en_sy[1];
   assign vb = vb_sy[1];
   assign oc = oc_sy[1];
   assign i2c_mode = ~mf_sy[1];

   function automatic logic [6:0] own_addr(input logic hi);
      logic [6:0] a;
      a = TCCI_ADDR_BASE;
      a[TCCI_ADDR_SEL_BIT] = hi;
      return a;
   endfunction : own_addr

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         en_d <= 1'b0;
         oc_d <= 1'b0;
      end else begin
         scl_d <= scl_f;
         sda_d <= sda_f;
         en_d <= en;
         oc_d <= oc;
      end
   end

   wire scl_rise = scl_f & ~scl_d;
   wire scl_fall = ~scl_f & scl_d;
   wire start_c = scl_f & scl_d & sda_d & ~sda_f;
   wire stop_c = scl_f & scl_d & ~sda_d & sda_f;
   wire en_edge = en ^ en_d;

   // Next byte must be fetched before the pointer moves on
   assign rd_ptr = (state == TCCI_RD && ptr != TCCI_LAST_REG) ?
                   ptr + 8'h01 : ptr;
   always_comb begin
      unique case (rd_ptr)
         TCCI_REG_ID: rd_byte = TCCI_ID_VALUE;
         TCCI_REG_CONTROL: rd_byte = control;
         TCCI_REG_EVENT_FLAGS: rd_byte = event_flags;
         TCCI_REG_ATTACH_STATUS: rd_byte = attach_status;
         default: rd_byte = 8'h00;
      endcase
   end

   // pointer restarts at first register each transfer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= TCCI_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         ptr <= TCCI_REG_ID;
         ack_phase <= 1'b0;
         rd_nack <= 1'b0;
         sda_oe <= 1'b0;
      end else if (en_edge || !i2c_mode || stop_c) begin
         state <= TCCI_IDLE;
         sda_oe <= 1'b0;
         ack_phase <= 1'b0;
      end else if (start_c) begin
         state <= TCCI_ADDR;
         bitcnt <= 4'h0;
         ptr <= TCCI_REG_ID;
         ack_phase <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         unique case (state)
            TCCI_IDLE: begin
               sda_oe <= 1'b0;
            end
            TCCI_ADDR, TCCI_WR: begin
               if (scl_rise && !ack_phase) begin
                  shreg <= {shreg[6:0], sda_f};
                  bitcnt <= bitcnt + 4'h1;
               end
               if (scl_fall && !ack_phase && bitcnt == 4'h8) begin
                  ack_phase <= 1'b1;
                  bitcnt <= 4'h0;
                  if (state == TCCI_ADDR &&
                      shreg[7:1] != own_addr(ms_sy[1]))
                     state <= TCCI_IDLE;
                  else
                     sda_oe <= 1'b1;
               end else if (scl_fall && ack_phase) begin
                  ack_phase <= 1'b0;
                  sda_oe <= 1'b0;
                  if (state == TCCI_ADDR && shreg[0]) begin
                     state <= TCCI_RD;
                     shreg <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     bitcnt <= 4'h1;
                  end else if (state == TCCI_ADDR) begin
                     state <= TCCI_WR;
                  end else if (ptr != TCCI_LAST_REG) begin
                     ptr <= ptr + 8'h01;
                  end
               end
            end
            TCCI_RD: begin
               if (scl_rise && ack_phase)
                  rd_nack <= sda_f;
               if (scl_fall && !ack_phase) begin
                  if (bitcnt == 4'h8) begin
                     ack_phase <= 1'b1;
                     sda_oe <= 1'b0;
                  end else begin
                     sda_oe <= ~shreg[7 - 3'(bitcnt)];
                     bitcnt <= bitcnt + 4'h1;
                  end
               end else if (scl_fall && ack_phase) begin
                  ack_phase <= 1'b0;
                  if (rd_nack) begin
                     state <= TCCI_IDLE;
                  end else begin
                     ptr <= rd_ptr;
                     shreg <= rd_byte;
                     bitcnt <= 4'h1;
                     sda_oe <= ~rd_byte[7];
                  end
               end
            end
            default: state <= TCCI_IDLE;
         endcase
      end
   end
   assign sda_out = 1'b0;

   assign ctl_wr = state == TCCI_WR && scl_fall && !ack_phase &&
                   bitcnt == 4'h8 && ptr == TCCI_REG_CONTROL;
   // read of event register clears flags
   assign flags_clr = state == TCCI_RD && scl_fall && ack_phase &&
                      ptr == TCCI_REG_EVENT_FLAGS;

   // role loads from pin once, writes may change it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         control <= TCCI_CONTROL_RST;
         role_loaded <= 1'b0;
      end else if (ctl_wr) begin
         control <= shreg;
         role_loaded <= 1'b1;
      end else if (!role_loaded) begin
         control[TCCI_CTL_ROLE_LO +: 2] <= role_pin;
         role_loaded <= 1'b1;
      end
   end

   wire [1:0] role = control[TCCI_CTL_ROLE_LO +: 2];
   wire active = en && !control[TCCI_CTL_SLEEP_BIT];

   // dual role toggling with 50 ms dwell
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tog_cnt <= 32'h0;
         host_now <= 1'b0;
      end else if (!active || en_edge) begin
         tog_cnt <= 32'h0;
         host_now <= 1'b0;
      end else if (role != TCCI_ROLE_DUAL) begin
         host_now <= role == TCCI_ROLE_HOST;
         tog_cnt <= 32'h0;
      end else if (!attached) begin
         if (tog_cnt == 32'(TOGGLE_CYC - 1)) begin
            tog_cnt <= 32'h0;
            host_now <= ~host_now;
         end else begin
            tog_cnt <= tog_cnt + 32'h1;
         end
      end
   end

   // device role attach from bus power
   assign attached = active && (host_now ? cc_attach : vb);

   always_comb begin
      next_status = 8'h00;
      next_status[0] = attached;
      next_status[1] = host_now;
      next_status[3:2] = host_now ? control[TCCI_CTL_CUR_LO +: 2]
                                  : cc_host_current;
      next_status[4] = active && cc_audio;
      next_status[5] = active && cc_debug;
   end

   logic status_chg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         attach_status <= 8'h00;
         attached_d <= 1'b0;
         status_chg <= 1'b0;
      end else begin
         attach_status <= next_status;
         attached_d <= attached;
         status_chg <= next_status != attach_status;
      end
   end

   // flags set, set wins over clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         event_flags <= TCCI_EVENT_RST;
      end else begin
         if (flags_clr)
            event_flags <= 8'h00;
         if (attached && !attached_d)
            event_flags[TCCI_EV_ATTACH_BIT] <= 1'b1;
         if (!attached && attached_d)
            event_flags[TCCI_EV_DETACH_BIT] <= 1'b1;
         if (oc && !oc_d)
            event_flags[TCCI_EV_FAULT_BIT] <= 1'b1;
      end
   end

   // mask holds output released; disabled releases
   logic irq_pend;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_pend <= 1'b0;
      end else if (control[TCCI_CTL_MASK_BIT]) begin
         irq_pend <= 1'b0;
      end else if (status_chg || (oc && !oc_d)) begin
         irq_pend <= 1'b1;
      end else if (flags_clr) begin
         irq_pend <= 1'b0;
      end
   end
   assign irq_oe = irq_pend && en;
   assign irq_out_n = 1'b0;

   // attach pin only for host-role device attach
   assign attach_oe = en && host_now && attached && !cc_audio && !cc_debug;
   assign attach_indicator_pin = 1'b0;

   assign cc_source_on = active && host_now;
   assign cc_pulldown_on = !cc_source_on;
   assign cc_source_level = control[TCCI_CTL_CUR_LO +: 2];
endmodule : tcci_top
`default_nettype wire

// ---- tb/tcci_host_model.sv ----
// Host processor model acting as serial bus controller
`timescale 1ns/1ps
`default_nettype none
module tcci_host_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // Clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Data moves only while the clock is low; sampled late in the high phase
   // Long low phase leaves room for the target's input latency
   // register traffic only, no power messaging
   task automatic bit_io(input logic b, output logic r);
      #100 sda_low = !b;
      #500 scl = 1'b1;
      #200 r = sda;
      scl = 1'b0;
   endtask : bit_io
   task automatic start;
      @(negedge clk);
      sda_low = 1'b1;
      #400 scl = 1'b0;
   endtask : start
   task automatic stop;
      #200 sda_low = 1'b1;
      #200 scl = 1'b1;
      #400 sda_low = 1'b0;
      #400;
   endtask : stop
   // Byte out, most significant bit first
   task automatic put(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(d[i], nak);
      bit_io(1'b1, nak);
   endtask : put
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask : get
endmodule : tcci_host_model
`default_nettype wire

// ---- tb/tcci_properties.sv ----
// Port-level checks of the Type-C port control block
`timescale 1ns/1ps
`default_nettype none
module tcci_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sda_oe,
   input wire logic mode_sel_float,
   input wire logic enable_in_n,
   input wire logic irq_oe,
   input wire logic attach_oe,
   input wire logic cc_source_on,
   input wire logic cc_pulldown_on,
   input wire logic i2c_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Four cycles cover the input synchroniser
   sequence s_off;
      enable_in_n [*4];
   endsequence
   sequence s_pin_mode;
      mode_sel_float [*4];
   endsequence
   a_irq_reset_quiet: assert property (
      $rose(rstn) |-> !irq_oe) else $error("irq after reset");
   a_pin_mode_off: assert property (
      s_pin_mode |-> !i2c_mode && !sda_oe) else $error("i2c in pin mode");
   a_i2c_mode_on: assert property (
      !mode_sel_float [*4] |-> i2c_mode) else $error("i2c not enabled");
   a_i2c_returns: assert property (
      $fell(mode_sel_float) |-> ##[1:8] i2c_mode) else $error("i2c stuck");
   a_cc_term_excl: assert property (
      !(cc_source_on && cc_pulldown_on)) else $error("cc both on");
   a_attach_host_only: assert property (
      attach_oe |-> cc_source_on) else $error("attach pin off host role");
   a_disabled_quiet: assert property (
      s_off |-> !attach_oe && !irq_oe && cc_pulldown_on)
      else $error("outputs active while disabled");
   a_ack_holds: assert property (
      $rose(sda_oe) |-> sda_oe [*6]) else $error("data bit too short");
endmodule : tcci_properties
`default_nettype wire

// ---- tb/tcci_tb_top.sv ----
// Self-checking bench for the Type-C port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
   begin \
      n_checks++; \
      if ((a) !== (b)) begin \
         num_errors++; \
         $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); \
      end \
   end
module tcci_tb_top;
   import tcci_pkg::*;
   localparam int TOG = 20;
   localparam logic [6:0] ADR_HI = 7'h2d;
   localparam logic [6:0] ADR_LO = 7'h0d;
   logic clk = 1'b0;
   logic rstn, scl, sda, host_low, sda_oe, mode_sel_high, mode_sel_float;
   logic enable_in_n, bus_power_sense, overcurrent_event, cc_attach;
   logic cc_audio, cc_debug, irq_oe, attach_oe, cc_source_on;
   logic cc_pulldown_on, i2c_mode, nak;
   logic [1:0] role_pin, cc_host_current, cc_source_level;
   logic [7:0] rb [4];
   int c;
   int n_checks = 0;
   int num_errors = 0;
   always #50 clk = ~clk;
   // Open-drain data line with pull-up
   assign sda = !(host_low || sda_oe);
   tcci_top #(.TOGGLE_CYC(TOG)) dut (
      .clk, .rstn, .scl_in(scl), .sda_in(sda), .sda_oe, .sda_out(),
      .mode_sel_high, .mode_sel_float, .role_pin, .enable_in_n,
      .bus_power_sense, .overcurrent_event, .cc_attach, .cc_host_current,
      .cc_audio, .cc_debug, .irq_out_n(), .irq_oe, .attach_indicator_pin(),
      .attach_oe, .cc_source_on, .cc_source_level, .cc_pulldown_on,
      .i2c_mode
   );
   tcci_host_model host (.clk, .sda, .scl, .sda_low(host_low));
   task automatic nx(input int n);
      repeat (n) @(negedge clk);
   endtask : nx
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // Every read starts at the first register
   task automatic rd(input logic [6:0] a, input int n, input logic en);
      host.start;
      host.put({a, 1'b1}, nak);
      `CHK(nak, en)
      for (int i = 0; i < n && !nak; i++) host.get(i == n - 1, rb[i]);
      host.stop;
   endtask : rd
   // Control is reached by passing the first register
   task automatic wr(input logic [7:0] v);
      host.start;
      host.put({ADR_HI, 1'b0}, nak);
      host.put(8'h00, nak);
      host.put(v, nak);
      `CHK(nak, 1'b0)
      host.stop;
   endtask : wr
   task automatic wait_irq;
      n_checks++;
      for (int i = 0; i < 60 && irq_oe !== 1'b1; i++) nx(1);
      if (irq_oe !== 1'b1) begin
         num_errors++;
         complete_run;
      end
   endtask : wait_irq
   task automatic gap(output int n);
      logic s;
      s = cc_source_on;
      n = 0;
      while (cc_source_on === s && n < 100) begin
         nx(1);
         n++;
      end
   endtask : gap
   initial begin
      rstn = 1'b0;
      mode_sel_high = 1'b1;
      mode_sel_float = 1'b0;
      role_pin = TCCI_ROLE_HOST;
      enable_in_n = 1'b0;
      bus_power_sense = 1'b0;
      overcurrent_event = 1'b0;
      cc_attach = 1'b0;
      cc_host_current = 2'h0;
      cc_audio = 1'b0;
      cc_debug = 1'b0;
      nx(16);
      rstn = 1'b1;
      nx(8);
      rd(ADR_HI, 4, 1'b0);
      `CHK(rb[1], 8'h02)
      `CHK(rb[2], 8'h00)
      `CHK(irq_oe, 1'b0)
      rd(ADR_LO, 1, 1'b1);
      mode_sel_high = 1'b0;
      rd(ADR_LO, 1, 1'b0);
      mode_sel_float = 1'b1;
      nx(10);
      `CHK(i2c_mode, 1'b0)
      rd(ADR_LO, 1, 1'b1);
      mode_sel_float = 1'b0;
      mode_sel_high = 1'b1;
      cc_attach = 1'b1;
      wait_irq;
      `CHK(attach_oe, 1'b1)
      `CHK(cc_source_on, 1'b1)
      rd(ADR_HI, 4, 1'b0);
      `CHK(rb[2][0], 1'b1)
      `CHK(rb[3][1:0], 2'h3)
      `CHK(irq_oe, 1'b0)
      wr(8'h13);
      `CHK(cc_source_level, 2'h2)
      cc_attach = 1'b0;
      nx(40);
      `CHK(irq_oe, 1'b0)
      wr(8'h12);
      `CHK(irq_oe, 1'b0)
      overcurrent_event = 1'b1;
      wait_irq;
      rd(ADR_HI, 3, 1'b0);
      `CHK(rb[1], 8'h12)
      `CHK(rb[2][2], 1'b1)
      overcurrent_event = 1'b0;
      enable_in_n = 1'b1;
      nx(10);
      `CHK(cc_pulldown_on, 1'b1)
      rd(ADR_HI, 2, 1'b0);
      `CHK(rb[1], 8'h12)
      enable_in_n = 1'b0;
      nx(10);
      `CHK(cc_source_on, 1'b1)
      wr(8'h14);
      gap(c);
      gap(c);
      `CHK(c inside {[TOG - 1:TOG + 1]}, 1'b1)
      cc_attach = 1'b1;
      nx(2 * TOG);
      gap(c);
      `CHK(c, 100)
      wr(8'h00);
      cc_attach = 1'b0;
      bus_power_sense = 1'b1;
      cc_host_current = 2'h2;
      cc_audio = 1'b1;
      cc_debug = 1'b1;
      nx(10);
      `CHK(cc_pulldown_on, 1'b1)
      `CHK(attach_oe, 1'b0)
      rd(ADR_HI, 4, 1'b0);
      `CHK(rb[3][0], 1'b1)
      `CHK(rb[3][3:2], 2'h2)
      `CHK(rb[3][5:4], 2'h3)
      complete_run;
   end
   // Guard against a hung transfer
   initial begin
      #8ms;
      num_errors++;
      complete_run;
   end
endmodule : tcci_tb_top
bind tcci_top tcci_properties u_props (
   .clk, .rstn, .sda_oe, .mode_sel_float, .enable_in_n, .irq_oe,
   .attach_oe, .cc_source_on, .cc_pulldown_on, .i2c_mode
);
`default_nettype wire
